// [adcsc_consts.svh]
// constants of the converter sequencing control: offsets, fields, resets, timing
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH
`define ADCSC_AW 18
`define ADCSC_IDX_MODE 16'hffc4
`define ADCSC_IDX_RESULT 16'hffc5
`define ADCSC_IDX_START 16'hffc6
`define ADCSC_IDX_STATUS 16'hffc8
`define ADCSC_IDX_MASK 16'hffc9
`define ADCSC_IDX_EDGE 16'hffca
`define ADCSC_MODE_RST 8'h00
`define ADCSC_MODE_RSV 8'h30
`define ADCSC_MODE_WMASK 8'hcf
`define ADCSC_START_RST 8'h7f
`define ADCSC_START_BIT 7
`define ADCSC_SPEED_BIT 7
`define ADCSC_EXT_EN_BIT 6
`define ADCSC_EDGE_BIT 4
`define ADCSC_SLOW_CYC 6'd62
`define ADCSC_FAST_CYC 6'd31
`define ADCSC_STEPS 6'd8
`define ADCSC_CH_BASE 4'h4
`define ADCSC_RESP_OKAY 2'b00
`define ADCSC_RESP_SLVERR 2'b10
`endif

// [adcsc_pkg.sv]
// types of the converter sequencing control
`include "adcsc_consts.svh"
package adcsc_pkg;
  typedef enum logic [1:0] {
    CS_IDLE = 2'b00,
    CS_SAMPLE = 2'b01,
    CS_TRIAL = 2'b10
  } adcsc_conv_t;

  typedef struct packed {
    logic awvalid;
    logic [`ADCSC_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`ADCSC_AW-1:0] araddr;
    logic rready;
  } adcsc_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcsc_axi_rsp_t;

  typedef struct packed {
    adcsc_conv_t cstate;
    logic [5:0] cnt;
    logic [2:0] bitpos;
    logic [7:0] sar;
    logic [3:0] conv_ch;
    logic [7:0] mode;
    logic edge_sel;
    logic status;
    logic mask;
    logic done;
    logic [7:0] result;
    logic trg_s1;
    logic trg_s2;
    logic trg_s3;
    logic cmp_s1;
    logic cmp_s2;
    logic aw_got;
    logic [`ADCSC_AW-1:0] awaddr;
    logic w_got;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } adcsc_state_t;
endpackage

// [adcsc_top.sv]
// converter sequencing control: register slave, start logic and sar sequencer
//
// Notes on behaviour
// - the result register is eight bits wide and software can only read it.
// - the result register can be read at any time, even mid-conversion, with no stall.
// - during a conversion the value read from the result register is the previous result.
// - a finished conversion stores its result, which then holds until the next conversion finishes.
// - reset leaves the result register as it was, so it is undefined after power-up.
// - reset sets the mode register to reserved bits five and four high, the rest low.
// - mode bit seven picks a conversion of 62 clocks when low and 31 clocks when high.
// - with mode bit six low the external start pin is ignored.
// - with mode bit six high the chosen edge of the external start pin starts a conversion.
// - the active edge of the start pin comes from a bit of the edge-select register.
// - mode bits five and four always read as one and ignore writes.
// - the low four mode bits choose the input channel for the next conversion.
// - each finished conversion sets the status flag, which raises an interrupt request only while the mask bit is set.
// - the channel mux serves up to eight inputs, fewer on a smaller build.
`include "adcsc_consts.svh"

module adcsc_top #(
  parameter int INPUT_COUNT = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire adcsc_pkg::adcsc_axi_req_t axi_req,
  output adcsc_pkg::adcsc_axi_rsp_t axi_rsp,
  input wire logic ext_start_pin,
  input wire logic comp_in,
  output logic [7:0] dac_code,
  output logic sample_hold,
  output logic [INPUT_COUNT-1:0] an_select,
  output logic irq
);
  import adcsc_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] word_idx(input logic [`ADCSC_AW-1:0] a);
    word_idx = a[`ADCSC_AW-1:2];
  endfunction

  function automatic logic [5:0] period_of(input logic fast);
    period_of = fast ? `ADCSC_FAST_CYC : `ADCSC_SLOW_CYC;
  endfunction

  // each of the eight trials gets an equal slice, the remainder goes to sampling
  function automatic logic [5:0] step_of(input logic fast);
    step_of = period_of(fast) / `ADCSC_STEPS;
  endfunction

  function automatic logic [5:0] sample_of(input logic fast);
    sample_of = period_of(fast) - (step_of(fast) * `ADCSC_STEPS);
  endfunction

  // ****************************************
  // state
  // ****************************************
  adcsc_state_t st_r;
  adcsc_state_t st_nxt;
  logic trig_edge;
  logic start_wr;
  logic conv_start;
  logic idle;
  logic wr_do;
  logic rd_do;
  logic [15:0] widx;
  logic [15:0] ridx;
  logic [3:0] ch_off;

  assign idle = (st_r.cstate == CS_IDLE);
  assign widx = word_idx(st_r.awaddr);
  assign ridx = word_idx(axi_req.araddr);
  assign wr_do = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_do = axi_req.arvalid && !st_r.rvalid;
  // edge detection reads only the second and third stages
  assign trig_edge = st_r.edge_sel ? (st_r.trg_s2 && !st_r.trg_s3) :
                     (!st_r.trg_s2 && st_r.trg_s3);
  assign start_wr = wr_do && st_r.wlane0 && (widx == `ADCSC_IDX_START) &&
                    st_r.wdata[`ADCSC_START_BIT];
  // a start that arrives while busy is dropped, the running conversion finishes
  assign conv_start = idle && (start_wr ||
                      (trig_edge && st_r.mode[`ADCSC_EXT_EN_BIT]));

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.trg_s1 = ext_start_pin;
    st_nxt.trg_s2 = st_r.trg_s1;
    st_nxt.trg_s3 = st_r.trg_s2;
    st_nxt.cmp_s1 = comp_in;
    st_nxt.cmp_s2 = st_r.cmp_s1;

    // sequencer
    case (st_r.cstate)
      CS_IDLE: begin
        if (conv_start) begin
          st_nxt.cstate = CS_SAMPLE;
          st_nxt.cnt = sample_of(st_r.mode[`ADCSC_SPEED_BIT]);
          st_nxt.sar = 8'h80;
          st_nxt.bitpos = 3'h7;
          st_nxt.conv_ch = st_r.mode[3:0];
        end
      end
      CS_SAMPLE: begin
        if (st_r.cnt == 6'h01) begin
          st_nxt.cstate = CS_TRIAL;
          st_nxt.cnt = step_of(st_r.mode[`ADCSC_SPEED_BIT]);
        end else begin
          st_nxt.cnt = st_r.cnt - 6'h01;
        end
      end
      CS_TRIAL: begin
        if (st_r.cnt == 6'h01) begin
          // comparator high means the input is at or above the trial code
          st_nxt.sar[st_r.bitpos] = st_r.cmp_s2;
          st_nxt.cnt = step_of(st_r.mode[`ADCSC_SPEED_BIT]);
          if (st_r.bitpos == 3'h0) begin
            st_nxt.cstate = CS_IDLE;
            st_nxt.result = {st_r.sar[7:1], st_r.cmp_s2};
            st_nxt.done = 1'b1;
          end else begin
            st_nxt.sar[st_r.bitpos - 3'h1] = 1'b1;
            st_nxt.bitpos = st_r.bitpos - 3'h1;
          end
        end else begin
          st_nxt.cnt = st_r.cnt - 6'h01;
        end
      end
      default: begin
        st_nxt.cstate = CS_IDLE;
      end
    endcase

    // write channels, taken in either order
    if (axi_req.awvalid && !st_r.aw_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_r.w_got && !st_r.bvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = axi_req.wdata[7:0];
      st_nxt.wlane0 = axi_req.wstrb[0];
    end
    if (wr_do) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `ADCSC_RESP_OKAY;
      case (widx)
        `ADCSC_IDX_MODE: begin
          if (st_r.wlane0) begin
            st_nxt.mode = st_r.wdata & `ADCSC_MODE_WMASK;
          end
        end
        `ADCSC_IDX_EDGE: begin
          if (st_r.wlane0) begin
            st_nxt.edge_sel = st_r.wdata[`ADCSC_EDGE_BIT];
          end
        end
        `ADCSC_IDX_MASK: begin
          if (st_r.wlane0) begin
            st_nxt.mask = st_r.wdata[0];
          end
        end
        // result is read-only, status clears by read and start acts only through start_wr: nothing is stored here
        `ADCSC_IDX_RESULT, `ADCSC_IDX_START, `ADCSC_IDX_STATUS: begin
          st_nxt.bresp = `ADCSC_RESP_OKAY;
        end
        default: begin
          st_nxt.bresp = `ADCSC_RESP_SLVERR;
        end
      endcase
    end
    if (st_r.bvalid && axi_req.bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel, never stalled by a running conversion
    if (st_r.rvalid && axi_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (rd_do) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `ADCSC_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      case (ridx)
        `ADCSC_IDX_MODE: begin
          st_nxt.rdata[7:0] = st_r.mode | `ADCSC_MODE_RSV;
        end
        `ADCSC_IDX_RESULT: begin
          // mid-conversion this still shows the previous result
          st_nxt.rdata[7:0] = st_r.result;
        end
        `ADCSC_IDX_START: begin
          st_nxt.rdata[7:0] = `ADCSC_START_RST;
          st_nxt.rdata[`ADCSC_START_BIT] = !idle;
        end
        `ADCSC_IDX_STATUS: begin
          st_nxt.rdata[0] = st_r.status;
          st_nxt.status = 1'b0;
        end
        `ADCSC_IDX_MASK: begin
          st_nxt.rdata[0] = st_r.mask;
        end
        `ADCSC_IDX_EDGE: begin
          st_nxt.rdata[`ADCSC_EDGE_BIT] = st_r.edge_sel;
        end
        default: begin
          st_nxt.rresp = `ADCSC_RESP_SLVERR;
        end
      endcase
    end

    // completion wins over a clearing read in the same cycle
    if (st_nxt.done) begin
      st_nxt.status = 1'b1;
    end

    if (sys_rst) begin
      st_nxt = '0;
      st_nxt.cstate = CS_IDLE;
      st_nxt.mode = `ADCSC_MODE_RST;
      st_nxt.result = st_r.result;
      // synchronisers keep tracking the pins, so no false edge follows release
      st_nxt.trg_s1 = ext_start_pin;
      st_nxt.trg_s2 = st_r.trg_s1;
      st_nxt.trg_s3 = st_r.trg_s2;
      st_nxt.cmp_s1 = comp_in;
      st_nxt.cmp_s2 = st_r.cmp_s1;
    end
  end

  always_ff @(posedge mclk) begin
    st_r <= st_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign ch_off = st_r.conv_ch - `ADCSC_CH_BASE;
  always_comb begin
    an_select = '0;
    // codes below the base select no input
    if (!idle && st_r.conv_ch >= `ADCSC_CH_BASE &&
        32'(ch_off) < INPUT_COUNT) begin
      an_select[ch_off[2:0]] = 1'b1;
    end
  end

  assign dac_code = st_r.sar;
  assign sample_hold = (st_r.cstate == CS_SAMPLE);
  assign irq = st_r.status && st_r.mask;
  assign axi_rsp.awready = !st_r.aw_got && !st_r.bvalid;
  assign axi_rsp.wready = !st_r.w_got && !st_r.bvalid;
  assign axi_rsp.bvalid = st_r.bvalid;
  assign axi_rsp.bresp = st_r.bresp;
  assign axi_rsp.arready = !st_r.rvalid;
  assign axi_rsp.rvalid = st_r.rvalid;
  assign axi_rsp.rdata = st_r.rdata;
  assign axi_rsp.rresp = st_r.rresp;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_RES_HOLD: assert property (!st_nxt.done |=> $stable(st_r.result))
    else $error("result changed without a completion");
  AST_RST_MODE: assert property (disable iff (1'b0)
    sys_rst |=> (st_r.mode | `ADCSC_MODE_RSV) == 8'h30)
    else $error("mode not at reset value after reset");
  AST_SLOW: assert property (conv_start && !st_r.mode[7] |-> ##63 st_r.done)
    else $error("slow conversion not 62 cycles");
  AST_FAST: assert property (conv_start && st_r.mode[7] |-> ##32 st_r.done)
    else $error("fast conversion not 31 cycles");
  AST_EXT_OFF: assert property (!st_r.mode[6] && !start_wr |-> !conv_start)
    else $error("start without enable or write");
  AST_EXT_ON: assert property (trig_edge && st_r.mode[6] && idle |=> !idle)
    else $error("enabled trigger edge did not start");
  AST_RSV: assert property (rd_do && ridx == `ADCSC_IDX_MODE
    |=> st_r.rdata[5:4] == 2'b11)
    else $error("reserved mode bits not one");
  AST_IRQ: assert property (st_r.done |-> st_r.status ##1 (st_r.status || $past(rd_do)))
    else $error("completion did not set status");
  AST_RDANY: assert property (rd_do |=> st_r.rvalid)
    else $error("read not answered in one cycle");
  AST_START: assert property (start_wr && idle |=> sample_hold)
    else $error("start write did not begin conversion");
  AST_CHAN: assert property (conv_start |=> st_r.conv_ch == $past(st_r.mode[3:0]))
    else $error("channel not latched at start");

  // ****************************************
  // register slave checks
  // ****************************************
  AST_WR_ANS: assert property (wr_do
    |=> st_r.bvalid)
    else $error("write not answered after both halves arrived");
  // only the six mapped registers answer okay
  AST_WR_ERR: assert property (wr_do && !(widx inside {`ADCSC_IDX_MODE, `ADCSC_IDX_RESULT,
    `ADCSC_IDX_START, `ADCSC_IDX_STATUS, `ADCSC_IDX_MASK, `ADCSC_IDX_EDGE})
    |=> st_r.bresp == `ADCSC_RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_RD_ERR: assert property (rd_do && !(ridx inside {`ADCSC_IDX_MODE, `ADCSC_IDX_RESULT,
    `ADCSC_IDX_START, `ADCSC_IDX_STATUS, `ADCSC_IDX_MASK, `ADCSC_IDX_EDGE})
    |=> st_r.rresp == `ADCSC_RESP_SLVERR)
    else $error("unmapped read not refused");
  AST_RD_HI: assert property (rd_do
    |=> st_r.rdata[31:8] == 24'h00_0000)
    else $error("read data above the low byte not zero");

  AST_RES_RO: assert property (wr_do && widx == `ADCSC_IDX_RESULT && !st_nxt.done
    |=> $stable(st_r.result))
    else $error("write reached the read-only result");
  AST_RES_RD: assert property (rd_do && ridx == `ADCSC_IDX_RESULT
    |=> st_r.rdata[7:0] == $past(st_r.result))
    else $error("result read did not return the stored result");
  AST_START_RD: assert property (rd_do && ridx == `ADCSC_IDX_START
    |=> st_r.rdata[6:0] == 7'h7f)
    else $error("start register low bits not one");
  AST_BUSY_RD: assert property (rd_do && ridx == `ADCSC_IDX_START
    |=> st_r.rdata[`ADCSC_START_BIT] == ($past(st_r.cstate) != CS_IDLE))
    else $error("start register busy bit wrong");
  AST_MODE_WR: assert property (wr_do && widx == `ADCSC_IDX_MODE && st_r.wlane0
    |=> st_r.mode == ($past(st_r.wdata) & `ADCSC_MODE_WMASK))
    else $error("mode write not stored with reserved bits masked");

  // a completion in the same cycle must win over the clearing read
  AST_STAT_CLR: assert property (rd_do && ridx == `ADCSC_IDX_STATUS && !st_nxt.done
    |=> !st_r.status)
    else $error("status read did not clear the flag");
  AST_SET_WINS: assert property (st_nxt.done
    |=> st_r.status)
    else $error("completion lost to a clearing read");

  // ****************************************
  // sequencer checks
  // ****************************************
  // sampling takes what is left of the period after eight equal trials
  AST_SMP_SLOW: assert property ($rose(sample_hold) && !st_r.mode[`ADCSC_SPEED_BIT]
    |-> sample_hold[*6] ##1 !sample_hold)
    else $error("slow sampling phase not six cycles");
  AST_SMP_FAST: assert property ($rose(sample_hold) && st_r.mode[`ADCSC_SPEED_BIT]
    |-> sample_hold[*7] ##1 !sample_hold)
    else $error("fast sampling phase not seven cycles");
  AST_SAR_FIRST: assert property (conv_start
    |=> dac_code == 8'h80)
    else $error("first trial code not mid-scale");
  AST_RES_DONE: assert property (st_r.done
    |-> st_r.result == st_r.sar)
    else $error("stored result differs from the final trial code");

  AST_CH_HOLD: assert property (!idle
    |=> $stable(st_r.conv_ch))
    else $error("channel changed during a conversion");
  AST_ONEHOT: assert property (!idle
    |-> $onehot0(an_select))
    else $error("more than one analog input selected");
  AST_NOSEL: assert property (!idle && st_r.conv_ch < `ADCSC_CH_BASE
    |-> an_select == '0)
    else $error("a channel code below the base selected an input");

  CVR_SLOW: cover property (conv_start && !st_r.mode[7] ##63 st_r.done);
  CVR_FAST: cover property (conv_start && st_r.mode[7] ##32 st_r.done);
  CVR_EXT: cover property (trig_edge && st_r.mode[6] && idle);
  CVR_BUSY_RD: cover property (rd_do && ridx == `ADCSC_IDX_RESULT && !idle);
  CVR_SET_WINS: cover property (st_nxt.done && rd_do && ridx == `ADCSC_IDX_STATUS);
endmodule

// [adcsc_analog_model.sv]
// analog source model: channel levels, sample-and-hold and comparator
module adcsc_analog_model #(
  parameter int N = 8
) (
  input wire logic mclk,
  input wire logic [N-1:0][7:0] levels,
  input wire logic [7:0] dac_code,
  input wire logic sample_hold,
  input wire logic [N-1:0] an_select,
  output logic comp_in
);
  logic [7:0] held;
  logic idle_tog = 1'b0;
  always @(posedge mclk) begin
    idle_tog <= ~idle_tog;
    if (sample_hold) begin
      for (int i = 0; i < N; i++) begin
        if (an_select[i]) held <= levels[i];
      end
    end
  end
  // no channel connected: comparator output wanders instead of holding
  assign comp_in = (an_select != '0) ? (held >= dac_code) : idle_tog;
endmodule

// [tb_adc_sequencing_control.sv]
// self-checking testbench of the converter sequencing control
`include "adcsc_consts.svh"
module tb_adc_sequencing_control;
  timeunit 1ns;
  timeprecision 1ps;
  import adcsc_pkg::*;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] level;
  } adcsc_row_t;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_start_pin = 1'b1;
  adcsc_axi_req_t req = '0;
  adcsc_axi_rsp_t rsp;
  logic comp_in, sample_hold, irq;
  logic [7:0] dac_code, rd, an_select, sel;
  logic [7:0][7:0] levels = '0;
  logic [1:0] resp;
  int failures = 0;
  int n_checks = 0;
  int cyc;
  // fast rows rely on the model comparator settling at once
  adcsc_row_t rows [8] = '{'{8'h04, 8'h00}, '{8'h85, 8'hff}, '{8'h06, 8'h80},
    '{8'h87, 8'h7f}, '{8'h08, 8'h55}, '{8'h89, 8'haa}, '{8'h0a, 8'h01}, '{8'h8b, 8'hfe}};
  always #4 mclk = ~mclk;
  adcsc_top #(.INPUT_COUNT(8)) dut (.mclk(mclk), .sys_rst(sys_rst), .axi_req(req),
    .axi_rsp(rsp), .ext_start_pin(ext_start_pin), .comp_in(comp_in), .dac_code(dac_code),
    .sample_hold(sample_hold), .an_select(an_select), .irq(irq));
  adcsc_analog_model #(.N(8)) model (.mclk(mclk), .levels(levels), .dac_code(dac_code),
    .sample_hold(sample_hold), .an_select(an_select), .comp_in(comp_in));
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    req.awaddr <= {idx, 2'b00};
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'h1;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (n > 200) begin failures++; test_done; end
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    // bready stays up, so a following call never drives it twice in one step
  endtask
  task automatic axi_rd(input logic [15:0] idx, output logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    req.araddr <= {idx, 2'b00};
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (n > 200) begin failures++; test_done; end
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata[7:0];
    r = rsp.rresp;
    // rready stays up for the same reason
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge mclk);
      n++;
      if (sample_hold === 1'b1) sel = an_select;
      if (n > 300) begin failures++; test_done; end
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    axi_rd(`ADCSC_IDX_MODE, rd, resp);
    `CHK(rd, 8'h30)
    axi_rd(`ADCSC_IDX_START, rd, resp);
    `CHK(rd, 8'h7f)
    `CHK(irq, 1'b0)
    axi_wr(`ADCSC_IDX_MASK, 8'h01, resp);
    foreach (rows[i]) begin
      levels[i] <= rows[i].level;
      axi_wr(`ADCSC_IDX_MODE, rows[i].mode, resp);
      axi_wr(`ADCSC_IDX_START, 8'h80, resp);
      wait_irq(cyc);
      `CHK(sel, 8'h01 << i)
      `CHK(cyc > (rows[i].mode[7] ? 28 : 59) && cyc < (rows[i].mode[7] ? 35 : 66), 1'b1)
      axi_rd(`ADCSC_IDX_STATUS, rd, resp);
      `CHK(rd, 8'h01)
      axi_rd(`ADCSC_IDX_STATUS, rd, resp);
      `CHK(rd, 8'h00)
      `CHK(irq, 1'b0)
      axi_rd(`ADCSC_IDX_RESULT, rd, resp);
      `CHK(rd, rows[i].level)
    end
    axi_wr(`ADCSC_IDX_MODE, 8'h00, resp);
    axi_rd(`ADCSC_IDX_MODE, rd, resp);
    `CHK(rd, 8'h30)
    axi_wr(`ADCSC_IDX_MODE, 8'hcf, resp);
    axi_rd(`ADCSC_IDX_MODE, rd, resp);
    `CHK(rd, 8'hff)
    axi_wr(`ADCSC_IDX_RESULT, 8'h00, resp);
    axi_rd(`ADCSC_IDX_RESULT, rd, resp);
    `CHK(rd, 8'hfe)
    axi_rd(16'hffc7, rd, resp);
    `CHK(resp, 2'b10)
    axi_wr(16'hffc7, 8'h00, resp);
    `CHK(resp, 2'b10)
    // channel code below the base: the conversion runs with no input connected
    axi_wr(`ADCSC_IDX_MODE, 8'h80, resp);
    axi_wr(`ADCSC_IDX_START, 8'h80, resp);
    wait_irq(cyc);
    `CHK(sel, 8'h00)
    axi_rd(`ADCSC_IDX_STATUS, rd, resp);
    `CHK(rd, 8'h01)
    // masked completion: status set, irq held low until unmasked
    axi_wr(`ADCSC_IDX_MASK, 8'h00, resp);
    axi_wr(`ADCSC_IDX_MODE, 8'h04, resp);
    axi_wr(`ADCSC_IDX_START, 8'h80, resp);
    axi_rd(`ADCSC_IDX_START, rd, resp);
    `CHK(rd, 8'hff)
    axi_rd(`ADCSC_IDX_RESULT, rd, resp);
    `CHK(resp, 2'b00)
    repeat (80) @(posedge mclk);
    `CHK(irq, 1'b0)
    axi_wr(`ADCSC_IDX_MASK, 8'h01, resp);
    `CHK(irq, 1'b1)
    axi_rd(`ADCSC_IDX_STATUS, rd, resp);
    `CHK(rd, 8'h01)
    levels[0] <= 8'h3c;
    ext_start_pin <= 1'b0;
    repeat (5) @(posedge mclk);
    ext_start_pin <= 1'b1;
    repeat (80) @(posedge mclk);
    `CHK(irq, 1'b0)
    axi_wr(`ADCSC_IDX_MODE, 8'h44, resp);
    ext_start_pin <= 1'b0;
    wait_irq(cyc);
    axi_rd(`ADCSC_IDX_RESULT, rd, resp);
    `CHK(rd, 8'h3c)
    axi_rd(`ADCSC_IDX_STATUS, rd, resp);
    axi_wr(`ADCSC_IDX_EDGE, 8'h10, resp);
    ext_start_pin <= 1'b1;
    wait_irq(cyc);
    `CHK(cyc < 75, 1'b1)
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    axi_rd(`ADCSC_IDX_RESULT, rd, resp);
    `CHK(rd, 8'h3c)
    test_done;
  end
endmodule
